//--- rtl/eeprom_ctrl_pkg.sv
// constants, register map and field layout for the data eeprom access controller
// assumes a 100 MHz system clock and a 32-bit axi4-lite register bus
package eeprom_ctrl_pkg;

  // clock
  localparam int CLK_PERIOD_NS = 10;

  // bus geometry and responses
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_INT_ENABLE_2 = 12'hfa0;
  localparam logic [11:0] IDX_INT_FLAGS_2 = 12'hfa1;
  localparam logic [11:0] IDX_INT_PRIORITY_2 = 12'hfa2;
  localparam logic [11:0] IDX_NVM_CTRL = 12'hfa6;
  localparam logic [11:0] IDX_UNLOCK_KEY = 12'hfa7;
  localparam logic [11:0] IDX_EE_DATA = 12'hfa8;
  localparam logic [11:0] IDX_EE_ADDR = 12'hfa9;
  localparam logic [11:0] IDX_INT_CLEAR_2 = 12'hfb0;

  // field positions and reset values
  localparam int DONE_FLAG_BIT = 4;
  localparam logic [4:0] INT_ENABLE_RST = 5'h00;
  localparam logic [4:0] INT_PRIORITY_RST = 5'h1f;
  localparam logic [7:0] EE_ADDR_RST = 8'h00;
  localparam logic [7:0] EE_DATA_RST = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // unlock key bytes
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  // array size
  localparam int EE_DEPTH = 256;

  // control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic mem_select;
    logic config_space_select;
    logic spare;
    logic row_erase;
    logic write_abort_flag;
    logic write_permit;
    logic write_trigger;
    logic read_trigger;
  } nvm_ctrl_s;

  localparam nvm_ctrl_s NVM_CTRL_RST = '0;

  typedef enum logic [1:0] {
    KEY_NONE,
    KEY_GOT_FIRST,
    KEY_ARMED
  } key_state_e;

  typedef enum logic [1:0] {
    WR_IDLE,
    WR_ERASE,
    WR_PROGRAM
  } write_state_e;

endpackage

//--- rtl/data_eeprom_access_ctrl.sv
// data eeprom access controller: 256-byte array behind an axi4-lite register slave
// assumes single clock clk_sys_i, async low power-on reset, synchronous external and
// watchdog reset levels, and a well-behaved axi4-lite master
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps

module data_eeprom_access_ctrl
  import eeprom_ctrl_pkg::*;
#(
  parameter int WRITE_TIME_NS = 4000000
)
(
  // clock and resets
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic external_reset_pin_i,
  input wire logic watchdog_reset_i,
  // axi4-lite write address and data
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [ADDR_W-1:0] awaddr_i,
  input wire logic [2:0] awprot_i,
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  // axi4-lite write response
  output logic bvalid_o,
  input wire logic bready_i,
  output logic [1:0] bresp_o,
  // axi4-lite read
  input wire logic arvalid_i,
  output logic arready_o,
  input wire logic [ADDR_W-1:0] araddr_i,
  input wire logic [2:0] arprot_i,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [DATA_W-1:0] rdata_o,
  output logic [1:0] rresp_o,
  // interrupt
  output logic irq_o
);

  // write time in cycles, split evenly between erase and program phases
  localparam int WRITE_CYCLES = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES = WRITE_CYCLES / 2;
  localparam int PROG_CYCLES = WRITE_CYCLES - ERASE_CYCLES;

  // bus state
  logic aw_pend_ff, nxt_aw_pend;
  logic [ADDR_W-1:0] aw_addr_ff, nxt_aw_addr;
  logic w_pend_ff, nxt_w_pend;
  logic [7:0] w_byte_ff, nxt_w_byte;
  logic w_lane0_ff, nxt_w_lane0;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;

  // core state
  nvm_ctrl_s ctrl_ff, nxt_ctrl;
  logic [7:0] ee_addr_ff, nxt_ee_addr;
  logic [7:0] ee_data_ff, nxt_ee_data;
  logic [4:0] int_enable_ff, nxt_int_enable;
  logic [4:0] int_priority_ff, nxt_int_priority;
  logic done_flag_ff, nxt_done_flag;
  logic irq_ff, nxt_irq;
  key_state_e key_ff, nxt_key;
  write_state_e wstate_ff, nxt_wstate;
  logic [31:0] tmr_ff, nxt_tmr;

  // array write port
  logic [7:0] ee_mem [EE_DEPTH];
  logic mem_we;
  logic [7:0] mem_wd;

  // decoded bus events
  logic wr_fire;
  logic ar_fire;
  logic [11:0] w_idx;
  logic [11:0] r_idx;
  logic w_mapped;
  logic r_mapped;
  logic [7:0] rd_byte;

  // the slave answers a write once both halves are held and no response is pending
  assign wr_fire = aw_pend_ff & w_pend_ff & ~bvalid_ff;
  assign ar_fire = arvalid_i & arready_o; // a held request is taken once, on the shown ready
  assign w_idx = aw_addr_ff[13:2];
  assign r_idx = araddr_i[13:2];

  // address decode shared by both directions
  function automatic logic idx_mapped(input logic [ADDR_W-1:0] addr);
    logic [11:0] idx;
    idx = addr[13:2];
    idx_mapped = (addr[15:14] == 2'h0) && (addr[1:0] == 2'h0) &&
                 (idx == IDX_INT_ENABLE_2 || idx == IDX_INT_FLAGS_2 ||
                  idx == IDX_INT_PRIORITY_2 || idx == IDX_NVM_CTRL ||
                  idx == IDX_UNLOCK_KEY || idx == IDX_EE_DATA ||
                  idx == IDX_EE_ADDR || idx == IDX_INT_CLEAR_2);
  endfunction

  assign w_mapped = idx_mapped(aw_addr_ff);
  assign r_mapped = idx_mapped(araddr_i);

  // read mux on index bits alone; write-only locations and unmapped indices return zero
  always_comb
  begin
    rd_byte = 8'h00;
    case (r_idx)
      IDX_INT_ENABLE_2: rd_byte = {3'h0, int_enable_ff};
      IDX_INT_FLAGS_2: rd_byte = {3'h0, done_flag_ff, 4'h0};
      IDX_INT_PRIORITY_2: rd_byte = {3'h0, int_priority_ff};
      IDX_NVM_CTRL: rd_byte = {ctrl_ff[7:6], 1'b0, ctrl_ff[4:0]};
      IDX_UNLOCK_KEY: rd_byte = 8'h00;
      IDX_EE_DATA: rd_byte = ee_data_ff;
      IDX_EE_ADDR: rd_byte = ee_addr_ff;
      default: rd_byte = 8'h00;
    endcase
  end

  // bus channel next state: aw and w are taken independently, in either order
  always_comb
  begin
    nxt_aw_pend = aw_pend_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_pend = w_pend_ff;
    nxt_w_byte = w_byte_ff;
    nxt_w_lane0 = w_lane0_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (awvalid_i && awready_o)
    begin
      nxt_aw_pend = 1'b1;
      nxt_aw_addr = awaddr_i;
    end
    if (wvalid_i && wready_o)
    begin
      nxt_w_pend = 1'b1;
      nxt_w_byte = wdata_i[7:0];
      nxt_w_lane0 = wstrb_i[0];
    end
    if (bvalid_ff && bready_i)
    begin
      nxt_bvalid = 1'b0;
    end
    if (wr_fire)
    begin
      nxt_aw_pend = 1'b0;
      nxt_w_pend = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = w_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid_ff && rready_i)
    begin
      nxt_rvalid = 1'b0;
    end
    if (ar_fire)
    begin
      nxt_rvalid = 1'b1;
      nxt_rdata = {24'h000000, rd_byte};
      nxt_rresp = r_mapped ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // bus channel registers
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      aw_pend_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_pend_ff <= 1'b0;
      w_byte_ff <= 8'h00;
      w_lane0_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end
    else
    begin
      aw_pend_ff <= nxt_aw_pend;
      aw_addr_ff <= nxt_aw_addr;
      w_pend_ff <= nxt_w_pend;
      w_byte_ff <= nxt_w_byte;
      w_lane0_ff <= nxt_w_lane0;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  // core next state: registers, unlock sequence and self-timed write
  always_comb
  begin
    nvm_ctrl_s wr_ctrl;
    logic reg_wr;
    logic sel_data;
    logic busy;
    wr_ctrl = nvm_ctrl_s'(w_byte_ff);
    reg_wr = wr_fire & w_mapped & w_lane0_ff; // lane 0 carries the byte
    busy = (wstate_ff != WR_IDLE);
    sel_data = ~wr_ctrl.mem_select & ~wr_ctrl.config_space_select;
    nxt_ctrl = ctrl_ff;
    nxt_ee_addr = ee_addr_ff;
    nxt_ee_data = ee_data_ff;
    nxt_int_enable = int_enable_ff;
    nxt_int_priority = int_priority_ff;
    nxt_done_flag = done_flag_ff;
    nxt_key = key_ff;
    nxt_wstate = wstate_ff;
    nxt_tmr = tmr_ff;
    mem_we = 1'b0;
    mem_wd = ee_data_ff;
    // interrupt registers stay reachable during a write
    if (reg_wr && w_idx == IDX_INT_ENABLE_2)
    begin
      nxt_int_enable = w_byte_ff[4:0];
    end
    if (reg_wr && w_idx == IDX_INT_PRIORITY_2)
    begin
      nxt_int_priority = w_byte_ff[4:0];
    end
    if (reg_wr && w_idx == IDX_INT_CLEAR_2 && w_byte_ff[DONE_FLAG_BIT])
    begin
      nxt_done_flag = 1'b0;
    end
    // any register write other than the next key byte breaks the unlock order (a control write only when idle); reads do not
    if (reg_wr && w_idx != IDX_UNLOCK_KEY && w_idx != IDX_NVM_CTRL)
    begin
      nxt_key = KEY_NONE;
    end
    if (reg_wr && w_idx == IDX_UNLOCK_KEY)
    begin
      case (key_ff)
        KEY_NONE: nxt_key = (w_byte_ff == KEY_FIRST) ? KEY_GOT_FIRST : KEY_NONE;
        KEY_GOT_FIRST: nxt_key = (w_byte_ff == KEY_SECOND) ? KEY_ARMED : KEY_NONE;
        default: nxt_key = KEY_NONE;
      endcase
    end
    // register writes while idle; a running write locks them out
    if (reg_wr && !busy)
    begin
      case (w_idx)
        IDX_EE_ADDR: nxt_ee_addr = w_byte_ff;
        IDX_EE_DATA: nxt_ee_data = w_byte_ff;
        IDX_NVM_CTRL:
        begin
          nxt_key = KEY_NONE;
          nxt_ctrl.mem_select = wr_ctrl.mem_select;
          nxt_ctrl.config_space_select = wr_ctrl.config_space_select;
          nxt_ctrl.row_erase = wr_ctrl.row_erase;
          nxt_ctrl.write_abort_flag = wr_ctrl.write_abort_flag;
          nxt_ctrl.write_permit = wr_ctrl.write_permit;
          // writing zero to a trigger does nothing; reads finish within this cycle
          if (wr_ctrl.read_trigger && sel_data)
          begin
            nxt_ee_data = ee_mem[ee_addr_ff];
          end
          // permit must already be set; setting both in one write starts nothing
          if (wr_ctrl.write_trigger && ctrl_ff.write_permit && key_ff == KEY_ARMED &&
              sel_data)
          begin
            nxt_ctrl.write_trigger = 1'b1;
            nxt_wstate = WR_ERASE;
            nxt_tmr = 32'h00000000;
          end
        end
        default: nxt_key = nxt_key;
      endcase
    end
    // self-timed erase then program of the addressed byte
    case (wstate_ff)
      WR_IDLE: nxt_tmr = nxt_tmr;
      WR_ERASE:
      begin
        nxt_tmr = tmr_ff + 32'h00000001;
        if (tmr_ff == 32'(ERASE_CYCLES - 1))
        begin
          mem_we = 1'b1;
          mem_wd = ERASED_BYTE;
          nxt_tmr = 32'h00000000;
          nxt_wstate = WR_PROGRAM;
        end
      end
      WR_PROGRAM:
      begin
        nxt_tmr = tmr_ff + 32'h00000001;
        if (tmr_ff == 32'(PROG_CYCLES - 1))
        begin
          mem_we = 1'b1;
          mem_wd = ee_data_ff;
          nxt_wstate = WR_IDLE;
          nxt_ctrl.write_trigger = 1'b0;
          nxt_done_flag = 1'b1;
        end
      end
      default: nxt_wstate = WR_IDLE;
    endcase
    // external and watchdog resets; permit survives them, only power-up clears it
    if (external_reset_pin_i || watchdog_reset_i)
    begin
      mem_we = 1'b0;
      nxt_ee_addr = EE_ADDR_RST;
      nxt_ee_data = EE_DATA_RST;
      nxt_ctrl.row_erase = 1'b0;
      nxt_ctrl.write_trigger = 1'b0;
      nxt_ctrl.read_trigger = 1'b0;
      nxt_key = KEY_NONE;
      nxt_wstate = WR_IDLE;
      nxt_tmr = 32'h00000000;
      if (busy)
      begin
        nxt_ctrl.write_abort_flag = 1'b1;
      end
    end
    nxt_ctrl.spare = 1'b0;
    nxt_irq = nxt_done_flag & nxt_int_enable[DONE_FLAG_BIT];
  end

  // core registers; the array itself is not reset
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ctrl_ff <= NVM_CTRL_RST;
      ee_addr_ff <= EE_ADDR_RST;
      ee_data_ff <= EE_DATA_RST;
      int_enable_ff <= INT_ENABLE_RST;
      int_priority_ff <= INT_PRIORITY_RST;
      done_flag_ff <= 1'b0;
      irq_ff <= 1'b0;
      key_ff <= KEY_NONE;
      wstate_ff <= WR_IDLE;
      tmr_ff <= 32'h00000000;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      ee_addr_ff <= nxt_ee_addr;
      ee_data_ff <= nxt_ee_data;
      int_enable_ff <= nxt_int_enable;
      int_priority_ff <= nxt_int_priority;
      done_flag_ff <= nxt_done_flag;
      irq_ff <= nxt_irq;
      key_ff <= nxt_key;
      wstate_ff <= nxt_wstate;
      tmr_ff <= nxt_tmr;
    end
  end

  // nonvolatile array; address is frozen during a write so ee_addr_ff is safe here
  always_ff @(posedge clk_sys_i)
  begin
    if (mem_we)
    begin
      ee_mem[ee_addr_ff] <= mem_wd;
    end
  end

  // outputs straight from flops; aw and w ready are low while their half is held, ar ready while a read answer is pending
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      awready_o <= 1'b0;
      wready_o <= 1'b0;
      arready_o <= 1'b0;
    end
    else
    begin
      awready_o <= ~nxt_aw_pend & ~(awvalid_i & awready_o);
      wready_o <= ~nxt_w_pend & ~(wvalid_i & wready_o);
      arready_o <= ~nxt_rvalid & ~(arvalid_i & arready_o);
    end
  end

  assign bvalid_o = bvalid_ff;
  assign bresp_o = bresp_ff;
  assign rvalid_o = rvalid_ff;
  assign rdata_o = rdata_ff;
  assign rresp_o = rresp_ff;
  assign irq_o = irq_ff;

endmodule

//--- dv/eeprom_ctrl_properties.sv
// checker for the eeprom controller register bus
// assumes it is bound to the controller top and sees only its ports
`timescale 1ns/1ps
module eeprom_ctrl_checker
  import eeprom_ctrl_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i, rst_b_i,
  // handshakes
  input wire logic arvalid_i, arready_o, rvalid_o, rready_i,
  input wire logic awvalid_i, awready_o, wvalid_i, wready_o, bvalid_o, bready_i,
  // payloads
  input wire logic [ADDR_W-1:0] araddr_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic [1:0] rresp_o, bresp_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  logic key_ff, bad_ff;
  // note what the pending read aimed at; only one read is ever open
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      key_ff <= 1'h0;
      bad_ff <= 1'h0;
    end
    else if (arvalid_i && arready_o)
    begin
      key_ff <= araddr_i == {2'h0, IDX_UNLOCK_KEY, 2'h0};
      bad_ff <= araddr_i == 16'h03fc; // a hole in the map
    end
  end
  sequence ar_take;
    arvalid_i && arready_o;
  endsequence
  sequence wr_take;
    awvalid_i && awready_o && wvalid_i && wready_o;
  endsequence
  a_read_answer: assert property (ar_take |-> ##[1:2] rvalid_o)
    else $error("read not answered in time");
  a_write_answer: assert property (wr_take |-> ##[1:3] bvalid_o)
    else $error("write not answered in time");
  a_read_cause: assert property ($rose(rvalid_o) |-> $past(arvalid_i) && $past(arready_o))
    else $error("read answer without request");
  a_read_ends: assert property (rvalid_o && rready_i |=> !rvalid_o)
    else $error("read answer not withdrawn");
  a_write_ends: assert property (bvalid_o && bready_i |=> !bvalid_o)
    else $error("write answer not withdrawn");
  a_key_zero: assert property (rvalid_o && key_ff |-> rdata_o == '0)
    else $error("key port read not zero");
  a_byte_wide: assert property (rvalid_o |-> rdata_o[31:8] == 24'h0)
    else $error("read data wider than a byte");
  a_hole_error: assert property (rvalid_o && bad_ff |-> rresp_o == RESP_SLVERR)
    else $error("unmapped read not refused");
endmodule

bind data_eeprom_access_ctrl eeprom_ctrl_checker u_chk (
  .clk_sys_i(clk_sys_i),
  .rst_b_i(rst_b_i),
  .arvalid_i(arvalid_i),
  .arready_o(arready_o),
  .rvalid_o(rvalid_o),
  .rready_i(rready_i),
  .awvalid_i(awvalid_i),
  .awready_o(awready_o),
  .wvalid_i(wvalid_i),
  .wready_o(wready_o),
  .bvalid_o(bvalid_o),
  .bready_i(bready_i),
  .araddr_i(araddr_i),
  .rdata_o(rdata_o),
  .rresp_o(rresp_o),
  .bresp_o(bresp_o)
);

//--- dv/test_data_eeprom_access_ctrl.sv
// self-checking bench for the data eeprom controller
// assumes the checker binds itself; the bench is the only bus master
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module test_data_eeprom_access_ctrl
  import eeprom_ctrl_pkg::*;
;
  logic clk_sys_i = 1'h0, rst_b_i = 1'h0, external_reset_pin_i = 1'h0, watchdog_reset_i = 1'h0;
  logic awvalid_i = 1'h0, wvalid_i = 1'h0, bready_i = 1'h0, arvalid_i = 1'h0, rready_i = 1'h0;
  logic [ADDR_W-1:0] awaddr_i = 16'h0, araddr_i = 16'h0;
  logic [DATA_W-1:0] wdata_i = 32'h0;
  logic [2:0] awprot_i = 3'h0, arprot_i = 3'h0;
  logic [3:0] wstrb_i = 4'h1;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, irq_o;
  logic [1:0] bresp_o, rresp_o, resp;
  logic [DATA_W-1:0] rdata_o;
  logic [7:0] rd;
  int errors = 0, checks_done = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  // short write time keeps the run small; each phase still spans cycles
  data_eeprom_access_ctrl #(.WRITE_TIME_NS(1000)) DUT (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .external_reset_pin_i(external_reset_pin_i),
    .watchdog_reset_i(watchdog_reset_i),
    .awvalid_i(awvalid_i),
    .awready_o(awready_o),
    .awaddr_i(awaddr_i),
    .awprot_i(awprot_i),
    .wvalid_i(wvalid_i),
    .wready_o(wready_o),
    .wdata_i(wdata_i),
    .wstrb_i(wstrb_i),
    .bvalid_o(bvalid_o),
    .bready_i(bready_i),
    .bresp_o(bresp_o),
    .arvalid_i(arvalid_i),
    .arready_o(arready_o),
    .araddr_i(araddr_i),
    .arprot_i(arprot_i),
    .rvalid_o(rvalid_o),
    .rready_i(rready_i),
    .rdata_o(rdata_o),
    .rresp_o(rresp_o),
    .irq_o(irq_o)
  );
  task automatic give_verdict();
    if (errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // one edge; a wait that runs past its bound ends the run
  task automatic tick(input int n);
    @(posedge clk_sys_i);
    if (n > 200)
    begin
      errors++;
      give_verdict();
    end
  endtask
  // bus write: address and data offered together, each dropped when taken
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    awaddr_i <= {2'h0, idx, 2'h0};
    wdata_i <= {24'h0, d};
    awvalid_i <= 1'h1;
    wvalid_i <= 1'h1;
    bready_i <= 1'h1;
    for (int n = 0; !bvalid_o; n++)
    begin
      tick(n);
      if (awready_o) awvalid_i <= 1'h0;
      if (wready_o) wvalid_i <= 1'h0;
    end
    resp = bresp_o;
    bready_i <= 1'h0;
    tick(0);
  endtask
  task automatic rdr(input logic [11:0] idx);
    araddr_i <= {2'h0, idx, 2'h0};
    arvalid_i <= 1'h1;
    rready_i <= 1'h1;
    for (int n = 0; !rvalid_o; n++)
    begin
      tick(n);
      if (arready_o) arvalid_i <= 1'h0;
    end
    rd = rdata_o[7:0];
    resp = rresp_o;
    rready_i <= 1'h0;
    tick(0);
  endtask
  task automatic rc(input string nm, input logic [11:0] idx, input logic [7:0] e);
    rdr(idx);
    `CHK(nm, e, rd)
  endtask
  // control value, both key bytes, then the trigger write; nothing is slipped in between
  task automatic arm(input logic [7:0] c, k1, k2, go);
    wr(IDX_NVM_CTRL, c);
    wr(IDX_UNLOCK_KEY, k1);
    wr(IDX_UNLOCK_KEY, k2);
    wr(IDX_NVM_CTRL, go);
  endtask
  task automatic t_reset();
    rc("ctrl", IDX_NVM_CTRL, 8'h00);
    rc("addr", IDX_EE_ADDR, 8'h00);
    rc("data", IDX_EE_DATA, 8'h00);
    rc("enable", IDX_INT_ENABLE_2, 8'h00);
    rc("prio", IDX_INT_PRIORITY_2, 8'h1f);
    wr(IDX_INT_PRIORITY_2, 8'h03);
    rc("prio", IDX_INT_PRIORITY_2, 8'h03);
    rc("flags", IDX_INT_FLAGS_2, 8'h00);
    wr(IDX_UNLOCK_KEY, KEY_FIRST);
    rc("key", IDX_UNLOCK_KEY, 8'h00);
    rdr(12'h0ff);
    `CHK("rresp", RESP_SLVERR, resp)
    wr(12'h0ff, 8'h12);
    `CHK("bresp", RESP_SLVERR, resp)
  endtask
  task automatic t_write();
    wr(IDX_INT_ENABLE_2, 8'h10);
    wr(IDX_EE_ADDR, 8'hff);
    wr(IDX_EE_DATA, 8'h5a);
    arm(8'h04, KEY_FIRST, KEY_SECOND, 8'h06);
    rc("busy", IDX_NVM_CTRL, 8'h06);
    wr(IDX_EE_ADDR, 8'h11);
    wr(IDX_EE_DATA, 8'h22);
    wr(IDX_NVM_CTRL, 8'h04);
    rc("busy", IDX_NVM_CTRL, 8'h06);
    `CHK("irq", 1'h0, irq_o)
    rd = 8'h02;
    for (int n = 0; rd[1]; n++)
    begin
      tick(n);
      rdr(IDX_NVM_CTRL);
    end
    rc("ctrl", IDX_NVM_CTRL, 8'h04);
    rc("flags", IDX_INT_FLAGS_2, 8'h10);
    `CHK("irq", 1'h1, irq_o)
    rc("addr", IDX_EE_ADDR, 8'hff);
    rc("data", IDX_EE_DATA, 8'h5a);
    wr(IDX_EE_DATA, 8'h00);
    rc("data", IDX_EE_DATA, 8'h00);
    wr(IDX_NVM_CTRL, 8'h05);
    rc("read", IDX_EE_DATA, 8'h5a);
    rc("ctrl", IDX_NVM_CTRL, 8'h04);
    // a write without the low byte lane must leave the data register alone
    wstrb_i <= 4'h0;
    wr(IDX_EE_DATA, 8'h77);
    wstrb_i <= 4'h1;
    rc("kept", IDX_EE_DATA, 8'h5a);
    wr(IDX_INT_CLEAR_2, 8'h10);
    rc("flags", IDX_INT_FLAGS_2, 8'h00);
    `CHK("irq", 1'h0, irq_o)
  endtask
  task automatic t_refuse();
    arm(8'h04, KEY_SECOND, KEY_FIRST, 8'h06);
    rc("order", IDX_NVM_CTRL, 8'h04);
    wr(IDX_NVM_CTRL, 8'h00);
    arm(8'h00, KEY_FIRST, KEY_SECOND, 8'h06);
    rc("same", IDX_NVM_CTRL, 8'h04);
    arm(8'h04, KEY_FIRST, KEY_SECOND, 8'hc6);
    rc("select", IDX_NVM_CTRL, 8'hc4);
    rc("flags", IDX_INT_FLAGS_2, 8'h00);
  endtask
  // reset pulse in mid-write; permit survives, abort shows
  task automatic t_abort(input logic wd);
    wr(IDX_EE_ADDR, 8'h20);
    wr(IDX_EE_DATA, 8'h33);
    arm(8'h04, KEY_FIRST, KEY_SECOND, 8'h06);
    external_reset_pin_i <= !wd;
    watchdog_reset_i <= wd;
    tick(0);
    external_reset_pin_i <= 1'h0;
    watchdog_reset_i <= 1'h0;
    tick(0);
    rc("abort", IDX_NVM_CTRL, 8'h0c);
    rc("addr", IDX_EE_ADDR, 8'h00);
    rc("data", IDX_EE_DATA, 8'h00);
    rc("flags", IDX_INT_FLAGS_2, 8'h00);
    wr(IDX_NVM_CTRL, 8'h00);
  endtask
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    rst_b_i <= 1'h1;
    tick(0);
    t_reset();
    t_write();
    t_refuse();
    t_abort(1'h0);
    t_abort(1'h1);
    give_verdict();
  end
endmodule
